/* include/agc_pkg.sv */
// gain management package: register map, field layout, reset values, timing
// assumes one fs strobe per stereo frame, times counted in sample periods
package agc_pkg;

	// stereo sample carrier
	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} stereo_t;

	typedef enum logic [1:0] {
		ALC_OFF = 2'b00,
		ALC_LIMIT = 2'b01,
		ALC_RECOVER = 2'b10
	} alc_state_t;

	// register offsets
	localparam logic [4:0] A_SEL = 5'h01;
	localparam logic [4:0] A_MUTE = 5'h02;
	localparam logic [4:0] A_TMR = 5'h03;
	localparam logic [4:0] A_LGAIN = 5'h04;
	localparam logic [4:0] A_RGAIN = 5'h05;
	localparam logic [4:0] A_ALC = 5'h06;
	localparam logic [4:0] A_REF = 5'h07;
	localparam logic [4:0] A_LVOL = 5'h08;
	localparam logic [4:0] A_RVOL = 5'h09;
	localparam logic [4:0] A_LPK_HI = 5'h0a;
	localparam logic [4:0] A_LPK_LO = 5'h0b;
	localparam logic [4:0] A_RPK_HI = 5'h0c;
	localparam logic [4:0] A_RPK_LO = 5'h0d;

	// field positions
	localparam int TMR_ZC = 0;
	localparam int TMR_LT = 2;
	localparam int TMR_WT = 4;
	localparam int ALC_EN = 0;
	localparam int ALC_BYP = 1;
	localparam int ALC_THR = 2;
	localparam int ALC_STEP = 3;
	localparam int ALC_FR = 4;

	// reset values
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic [7:0] TMR_RST = 8'h02;
	localparam logic [7:0] ALC_RST = 8'h00;
	localparam logic [7:0] REF_RST = 8'h10;
	localparam logic [7:0] GAIN_RST = 8'h00;
	localparam logic [7:0] VOL_RST = 8'h7f;

	// codes and levels
	localparam logic [7:0] VOL_MAX = 8'h8f;
	localparam logic [7:0] GAIN_ALC_MAX = 8'h7f;
	localparam logic [2:0] PAIR_LAST = 3'h4;
	localparam logic [2:0] RAMP_DIV = 3'h7;
	localparam int GAIN_FRAC = 14;
	localparam logic [22:0] THR0 = 23'h5a9df7;
	localparam logic [22:0] THR1 = 23'h4026e7;
	localparam logic [22:0] RLV0 = 23'h2d4efb;
	localparam logic [22:0] RLV1 = 23'h201373;
	localparam int FAST_SHIFT = 2;

	// zero crossing timeout, sample periods
	function automatic logic [12:0] zc_timeout(input logic [1:0] s);
		unique case (s)
			2'b00: zc_timeout = 13'h0120;
			2'b01: zc_timeout = 13'h0480;
			2'b10: zc_timeout = 13'h0900;
			2'b11: zc_timeout = 13'h1200;
		endcase
	endfunction

	// limiter and recovery wait periods, sample periods
	function automatic logic [12:0] period_sel(input logic [1:0] s);
		unique case (s)
			2'b00: period_sel = 13'h0040;
			2'b01: period_sel = 13'h0080;
			2'b10: period_sel = 13'h0100;
			2'b11: period_sel = 13'h0200;
		endcase
	endfunction

	// one 0.5 dB step within a 6 dB octave, +8 dB at zero, q14
	function automatic logic [15:0] vol_mant(input logic [3:0] f);
		unique case (f)
			4'h0: vol_mant = 16'ha0c3;
			4'h1: vol_mant = 16'h97c5;
			4'h2: vol_mant = 16'h8f47;
			4'h3: vol_mant = 16'h8744;
			4'h4: vol_mant = 16'h7fb2;
			4'h5: vol_mant = 16'h788e;
			4'h6: vol_mant = 16'h71cf;
			4'h7: vol_mant = 16'h6b71;
			4'h8: vol_mant = 16'h656f;
			4'h9: vol_mant = 16'h5fc2;
			4'ha: vol_mant = 16'h5a67;
			default: vol_mant = 16'h5558;
		endcase
	endfunction

endpackage

/* hdl/zc_gain_stage.sv */
// one channel of input gain: holds a pending code until a zero crossing
// or timeout, or applies it at once on immediate; assumes zero_cross and fs_tick are single-cycle strobes
`timescale 1ns/1ps
module zc_gain_stage import agc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic fs_tick,
	input wire logic zero_cross,
	input wire logic load,
	input wire logic immediate,
	input wire logic [7:0] target,
	input wire logic [12:0] timeout,
	output logic [7:0] gain
);

	logic pend_r;
	logic [7:0] tgt_r;
	logic [7:0] gain_r;
	logic [12:0] cnt_r;

	// apply at crossing, on timeout, or at once when the loop asks for it
	wire expired = fs_tick && (cnt_r >= timeout - 13'h0001);
	wire fire = pend_r && (immediate || zero_cross || expired);

	assign gain = gain_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_r <= 1'b0;
			tgt_r <= GAIN_RST;
			gain_r <= GAIN_RST;
			cnt_r <= 13'h0000;
		end else if (ce) begin
			if (load) begin
				pend_r <= 1'b1;
				tgt_r <= target;
				cnt_r <= 13'h0000;
			end else begin
				if (fire) begin
					gain_r <= tgt_r;
					pend_r <= 1'b0;
				end
				if (fs_tick && pend_r) begin
					cnt_r <= cnt_r + 13'h0001;
				end
			end
		end
	end

endmodule

/* hdl/vol_ramp.sv */
// one channel of output volume with a soft ramp toward its target code
// assumes fs_tick marks each new sample_in; output is one clock late
`timescale 1ns/1ps
module vol_ramp import agc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic fs_tick,
	input wire logic [23:0] sample_in,
	input wire logic [7:0] target,
	output logic [23:0] sample_out,
	output logic [7:0] level
);

	logic [7:0] lvl_r;
	logic [2:0] div_r;
	logic [23:0] out_r;

	// codes above the top are clamped rather than wrapped
	wire [7:0] tgt_c = (target > VOL_MAX) ? VOL_MAX : target;
	wire [7:0] att = VOL_MAX - lvl_r;
	wire [3:0] frac = 4'(att % 8'd12);
	wire [4:0] oct = 5'(att / 8'd12);
	wire signed [40:0] prod = $signed(sample_in) * $signed({1'b0, vol_mant(frac)});
	wire signed [40:0] shf = prod >>> (5'(GAIN_FRAC) + oct);
	wire sat_hi = !shf[40] && (shf[39:23] != 17'h00000);
	wire sat_lo = shf[40] && (shf[39:23] != 17'h1ffff);
	wire wrap = (div_r == RAMP_DIV - 3'h1);

	wire [23:0] scaled = (lvl_r == 8'h00) ? 24'h000000 :
		sat_hi ? 24'h7fffff : sat_lo ? 24'h800000 : shf[23:0];

	assign sample_out = out_r;
	assign level = lvl_r;

	// 143 steps of 7 frames fit in 1028
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lvl_r <= VOL_RST;
			div_r <= 3'h0;
			out_r <= 24'h000000;
		end else if (ce && fs_tick) begin
			out_r <= scaled;
			div_r <= wrap ? 3'h0 : div_r + 3'h1;
			if (wrap && lvl_r < tgt_c) begin
				lvl_r <= lvl_r + 8'h01;
			end else if (wrap && lvl_r > tgt_c) begin
				lvl_r <= lvl_r - 8'h01;
			end
		end
	end

endmodule

/* hdl/audio_gain_alc_control.sv */
// gain management of a stereo audio converter: input selector, analog
// input gain with zero crossing updates, output volume, peak hold, level control
// assumes samples arrive with in_valid once per frame and registers are
// accessed through the byte-wide port below, one access per cycle
`timescale 1ns/1ps
module audio_gain_alc_control import agc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] pair_select_pins,
	input wire logic soft_mute_pin,
	input wire logic in_valid,
	input wire stereo_t in_sample,
	output logic out_valid,
	output stereo_t out_sample,
	output logic [2:0] input_pair_select,
	output logic [4:0] pair_enable,
	output logic [7:0] left_analog_gain,
	output logic [7:0] right_analog_gain
);

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic [2:0] sel_r;
	logic soft_mute_request_r;
	logic [7:0] tmr_r;
	logic [7:0] alc_r;
	logic [7:0] ref_r;
	logic [7:0] rdata_r;
	logic out_valid_r;
	logic alc_on_d_r;

	wire fs_tick = ce && in_valid;
	wire wr_sel = reg_wr && (reg_addr == A_SEL);
	wire wr_mute = reg_wr && (reg_addr == A_MUTE);
	wire wr_tmr = reg_wr && (reg_addr == A_TMR);
	wire wr_alc = reg_wr && (reg_addr == A_ALC);
	wire wr_ref = reg_wr && (reg_addr == A_REF);

	wire alc_on = alc_r[ALC_EN];
	wire alc_byp = alc_r[ALC_BYP];
	wire alc_fast = alc_r[ALC_FR];
	wire alc_start = alc_on && !alc_on_d_r;
	wire alc_stop = !alc_on && alc_on_d_r;
	wire [12:0] zc_to = zc_timeout(tmr_r[TMR_ZC+:2]);

	wire soft_mute = soft_mute_request_r || soft_mute_pin;

	// host writes; every register holds its value while ce is low
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_r <= SEL_RST;
			soft_mute_request_r <= 1'b0;
			tmr_r <= TMR_RST;
			alc_r <= ALC_RST;
			ref_r <= REF_RST;
			alc_on_d_r <= 1'b0;
		end else if (ce) begin
			if (wr_sel) sel_r <= reg_wdata[2:0];
			if (wr_mute) soft_mute_request_r <= reg_wdata[0];
			if (wr_tmr) tmr_r <= reg_wdata;
			if (wr_alc) alc_r <= reg_wdata;
			if (wr_ref) ref_r <= reg_wdata;
			alc_on_d_r <= alc_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input selector

	// codes past the fifth pair fall back to the fifth
	function automatic logic [4:0] pair_onehot(input logic [2:0] c);
		pair_onehot = (c >= PAIR_LAST) ? 5'h10 : 5'(5'h01 << c);
	endfunction

	wire [2:0] sel_eff = (pair_select_pins != 3'h0) ? pair_select_pins : sel_r;
	assign input_pair_select = (sel_eff > PAIR_LAST) ? PAIR_LAST : sel_eff;
	assign pair_enable = pair_onehot(sel_eff);

	////////////////////////////////////////////////////////////////////////
	// level detection shared by the limiter

	function automatic logic [22:0] mag(input logic [23:0] s);
		logic [23:0] n;
		n = 24'h000000 - s;
		mag = s[23] ? ((n[23]) ? 23'h7fffff : n[22:0]) : s[22:0];
	endfunction

	wire [22:0] mag_l = mag(in_sample.left);
	wire [22:0] mag_r = mag(in_sample.right);
	wire [22:0] peak_in = (mag_l > mag_r) ? mag_l : mag_r;
	wire [22:0] thr = alc_r[ALC_THR] ? THR1 : THR0;
	wire [22:0] rlv = alc_r[ALC_THR] ? RLV1 : RLV0;
	wire over = fs_tick && (peak_in > thr);
	wire quiet = peak_in < rlv;

	////////////////////////////////////////////////////////////////////////
	// level control loop

	alc_state_t state_r;
	logic [7:0] alc_gain_r;
	logic [12:0] per_cnt_r;
	logic [12:0] wait_cnt_r;
	logic over_r;
	logic [7:0] gain_wr_l;

	wire [12:0] lim_base = alc_byp ? period_sel(tmr_r[TMR_LT+:2]) : zc_to;
	wire [12:0] wt_base = period_sel(tmr_r[TMR_WT+:2]);
	wire [12:0] lim_per = alc_fast ? (lim_base >> FAST_SHIFT) : lim_base;
	wire [12:0] wt_per = alc_fast ? (wt_base >> FAST_SHIFT) : wt_base;
	wire lim_exp = fs_tick && (per_cnt_r >= lim_per - 13'h0001);
	wire wt_exp = fs_tick && quiet && (wait_cnt_r >= wt_per - 13'h0001);
	wire [7:0] step = alc_r[ALC_STEP] ? 8'h02 : 8'h01;

	// over in recovery limits at once
	wire step_down = (state_r == ALC_LIMIT && lim_exp && (over_r || over)) ||
		(state_r == ALC_RECOVER && over);
	wire step_up = state_r == ALC_RECOVER && !over && wt_exp && alc_gain_r < ref_r;
	wire [7:0] gain_dn = (alc_gain_r > step) ? alc_gain_r - step : 8'h00;
	wire alc_load = alc_start || step_down || step_up;

	// state and period counters
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ALC_OFF;
			alc_gain_r <= GAIN_RST;
			per_cnt_r <= 13'h0000;
			wait_cnt_r <= 13'h0000;
			over_r <= 1'b0;
		end else if (ce) begin
			if (alc_start) alc_gain_r <= gain_wr_l;
			else if (step_down) alc_gain_r <= gain_dn;
			else if (step_up) alc_gain_r <= alc_gain_r + 8'h01;
			unique case (state_r)
				ALC_OFF: begin
					if (alc_on) state_r <= ALC_RECOVER;
					per_cnt_r <= 13'h0000;
					wait_cnt_r <= 13'h0000;
					over_r <= 1'b0;
				end
				ALC_LIMIT: begin
					if (!alc_on) begin
						state_r <= ALC_OFF;
					end else if (lim_exp) begin
						per_cnt_r <= 13'h0000;
						over_r <= 1'b0;
						wait_cnt_r <= 13'h0000;
						if (!(over_r || over)) state_r <= ALC_RECOVER;
					end else if (fs_tick) begin
						per_cnt_r <= per_cnt_r + 13'h0001;
						if (over) over_r <= 1'b1;
					end
				end
				ALC_RECOVER: begin
					if (!alc_on) begin
						state_r <= ALC_OFF;
					end else if (over) begin
						state_r <= ALC_LIMIT;
						per_cnt_r <= 13'h0000;
						over_r <= 1'b0;
					end else if (fs_tick && !quiet) begin
						wait_cnt_r <= 13'h0000;
					end else if (wt_exp) begin
						wait_cnt_r <= 13'h0000;
					end else if (fs_tick) begin
						wait_cnt_r <= wait_cnt_r + 13'h0001;
					end
				end
				default: state_r <= ALC_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per channel gain, volume and peak hold

	logic [7:0] vol_rd [2];
	logic [7:0] gain_rd [2];
	logic [15:0] peak_rd [2];
	logic [7:0] shadow_rd [2];
	logic [7:0] analog_gain [2];
	logic [23:0] vol_out [2];

	assign gain_wr_l = gain_rd[0];

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : ch
			logic [7:0] gain_wr_r;
			logic [7:0] vol_r;
			logic [15:0] peak_r;
			logic [7:0] shadow_r;
			logic sign_r;
			logic load_r;

			wire [4:0] a_gain = (g == 0) ? A_LGAIN : A_RGAIN;
			wire [4:0] a_vol = (g == 0) ? A_LVOL : A_RVOL;
			wire [4:0] a_hi = (g == 0) ? A_LPK_HI : A_RPK_HI;
			wire [23:0] smp = (g == 0) ? in_sample.left : in_sample.right;
			// high codes ignored under level control
			wire gain_ok = reg_wr && reg_addr == a_gain && !(alc_on && reg_wdata > GAIN_ALC_MAX);
			wire zc = fs_tick && (smp[23] != sign_r);
			wire rd_hi = reg_rd && reg_addr == a_hi;
			wire [22:0] mag_out = mag(vol_out[g]);
			wire [15:0] mag16 = mag_out[22:7];
			wire [15:0] peak_base = rd_hi ? 16'h0000 : peak_r;
			wire [7:0] tgt = alc_on ? alc_gain_r : gain_wr_r;

			always_ff @(posedge clk_sys) begin
				if (rst) begin
					gain_wr_r <= GAIN_RST;
					vol_r <= VOL_RST;
					peak_r <= 16'h0000;
					shadow_r <= 8'h00;
					sign_r <= 1'b0;
					load_r <= 1'b0;
				end else if (ce) begin
					if (gain_ok) gain_wr_r <= reg_wdata;
					if (reg_wr && reg_addr == a_vol) vol_r <= reg_wdata;
					if (fs_tick) sign_r <= smp[23];
					// back to last written on stop
					load_r <= (gain_ok && !alc_on) || alc_load || alc_stop;
					if (rd_hi) shadow_r <= peak_r[7:0];
					if (out_valid_r && mag16 > peak_base) peak_r <= mag16;
					else peak_r <= peak_base;
				end
			end

			zc_gain_stage u_stage (
				.clk_sys(clk_sys),
				.rst(rst),
				.ce(ce),
				.fs_tick(fs_tick),
				.zero_cross(zc),
				.load(load_r),
				.immediate(alc_on && alc_byp),
				.target(tgt),
				.timeout(zc_to),
				.gain(analog_gain[g])
			);

			vol_ramp u_vol (
				.clk_sys(clk_sys),
				.rst(rst),
				.ce(ce),
				.fs_tick(fs_tick),
				.sample_in(smp),
				.target(soft_mute ? 8'h00 : vol_r),
				.sample_out(vol_out[g]),
				.level()
			);

			assign vol_rd[g] = vol_r;
			assign gain_rd[g] = gain_wr_r;
			assign peak_rd[g] = peak_r;
			assign shadow_rd[g] = shadow_r;
		end
	endgenerate

	assign left_analog_gain = analog_gain[0];
	assign right_analog_gain = analog_gain[1];
	assign out_sample = '{left: vol_out[0], right: vol_out[1]};
	assign out_valid = out_valid_r;
	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// register read path, answers one cycle after the read strobe

	logic [7:0] rd_nxt;

	always_comb begin
		unique case (reg_addr)
			A_SEL: rd_nxt = {5'h00, sel_r};
			A_MUTE: rd_nxt = {7'h00, soft_mute_request_r};
			A_TMR: rd_nxt = tmr_r;
			A_LGAIN: rd_nxt = gain_rd[0];
			A_RGAIN: rd_nxt = gain_rd[1];
			A_ALC: rd_nxt = alc_r;
			A_REF: rd_nxt = ref_r;
			A_LVOL: rd_nxt = vol_rd[0];
			A_RVOL: rd_nxt = vol_rd[1];
			A_LPK_HI: rd_nxt = peak_rd[0][15:8];
			A_LPK_LO: rd_nxt = shadow_rd[0];
			A_RPK_HI: rd_nxt = peak_rd[1][15:8];
			A_RPK_LO: rd_nxt = shadow_rd[1];
			default: rd_nxt = 8'h00;
		endcase
	end

	// read data and output strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_r <= 8'h00;
			out_valid_r <= 1'b0;
		end else if (ce) begin
			if (reg_rd) rdata_r <= rd_nxt;
			out_valid_r <= in_valid;
		end
	end

endmodule

/* verification/audio_gain_alc_control_chk.sv */
// port checker for the gain block: selector, frame timing, reads, mute
// assumes one clock, synchronous reset, ce low freezing all state
`timescale 1ns/1ps
module agc_chk import agc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [4:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] pair_select_pins,
	input wire logic soft_mute_pin,
	input wire logic in_valid,
	input wire logic out_valid,
	input wire stereo_t out_sample,
	input wire logic [2:0] input_pair_select,
	input wire logic [4:0] pair_enable,
	input wire logic [7:0] left_analog_gain
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [10:0] mute_cnt_r;
	logic hi_rd;
	// frames under the mute pin; saturates so a long mute never wraps
	always_ff @(posedge clk_sys) begin
		if (rst || !soft_mute_pin) begin
			mute_cnt_r <= 11'h000;
		end else if (ce && in_valid && mute_cnt_r != 11'h7ff) begin
			mute_cnt_r <= mute_cnt_r + 11'h001;
		end
	end
	// quiet upper peak read: no frame result may reload the peak
	assign hi_rd = reg_rd && ce && reg_addr == A_LPK_HI && !out_valid;
////////////////////////////////////////////////////////////////
	pair_onehot_a: assert property (
		pair_enable == 5'h01 << input_pair_select)
		else $error("pair enable does not match select");
	pins_win_a: assert property (
		pair_select_pins != 3'h0 |-> input_pair_select ==
		(pair_select_pins > 3'h4 ? 3'h4 : pair_select_pins))
		else $error("select pins ignored");
	frame_out_a: assert property (
		in_valid && ce |=> out_valid)
		else $error("frame result missing");
	out_cause_a: assert property (
		out_valid && $past(ce) |-> $past(in_valid))
		else $error("frame result without input");
	sample_hold_a: assert property (
		$past(ce) && !out_valid |-> $stable(out_sample))
		else $error("output sample moved between frames");
	rdata_hold_a: assert property (
		$past(ce) && !$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without read");
	peak_clear_a: assert property (
		hi_rd && !$past(out_valid) ##1 !reg_rd && !out_valid ##1 hi_rd
		|=> reg_rdata == 8'h00)
		else $error("upper peak read did not clear");
	mute_silent_a: assert property (
		mute_cnt_r > 11'h405 && out_valid |-> out_sample == '0)
		else $error("output not silent after mute");
	ce_freeze_a: assert property (
		!ce |=> $stable(left_analog_gain) && $stable(out_sample))
		else $error("state moved with ce low");
endmodule
bind audio_gain_alc_control agc_chk agc_chk_i (
	.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair_select_pins(pair_select_pins),
	.soft_mute_pin(soft_mute_pin), .in_valid(in_valid), .out_valid(out_valid),
	.out_sample(out_sample), .input_pair_select(input_pair_select),
	.pair_enable(pair_enable), .left_analog_gain(left_analog_gain)
);

/* verification/line_source.sv */
// stereo line source: one frame every four clocks, optional sign swing
// assumes the bench sets amplitude; left and right carry opposite signs
`timescale 1ns/1ps
module line_source import agc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic run,
	input wire logic alt,
	input wire logic [22:0] amp,
	output logic in_valid,
	output stereo_t in_sample
);
	logic [1:0] div_r;
	logic neg_r;
	logic [23:0] s;
	assign s = neg_r ? -{1'b0, amp} : {1'b0, amp};
	// between frames the data is scrambled so stale samples are never trusted
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_r <= 2'h0;
			neg_r <= 1'b0;
			in_valid <= 1'b0;
			in_sample <= '0;
		end else begin
			div_r <= div_r + 2'h1;
			in_valid <= run && div_r == 2'h3;
			if (run && div_r == 2'h3) begin
				neg_r <= alt ? !neg_r : 1'b0;
				in_sample <= {s, -s};
			end else begin
				in_sample <= ~in_sample;
			end
		end
	end
endmodule

/* verification/testbench.sv */
// self-checking bench for the gain block with a register and peak model
// assumes line_source feeds frames and the checker is bound to the design
`timescale 1ns/1ps
module testbench import agc_pkg::*;;
	logic clk_sys, rst, ce, reg_wr, reg_rd, in_valid, out_valid, soft_mute_pin, run, alt;
	logic [4:0] reg_addr, pair_enable, b;
	logic [7:0] reg_wdata, reg_rdata, left_analog_gain, right_analog_gain, g;
	logic [2:0] pair_select_pins, input_pair_select;
	logic [22:0] amp;
	logic [15:0] pk_l, pk_r, pk;
	stereo_t in_sample, out_sample;
	logic [7:0] mdl [int];
	int fails, comparisons, n, e;
	int tmo [4] = '{288, 1152, 2304, 4608};
	audio_gain_alc_control audio_gain_alc_control_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pair_select_pins(pair_select_pins),
		.soft_mute_pin(soft_mute_pin), .in_valid(in_valid), .in_sample(in_sample),
		.out_valid(out_valid), .out_sample(out_sample), .input_pair_select(input_pair_select),
		.pair_enable(pair_enable), .left_analog_gain(left_analog_gain),
		.right_analog_gain(right_analog_gain));
	line_source line_source_i (.clk_sys(clk_sys), .rst(rst), .run(run), .alt(alt),
		.amp(amp), .in_valid(in_valid), .in_sample(in_sample));
	always #2 clk_sys = ~clk_sys;
////////////////////////////////////////////////////////////////
	function automatic logic [15:0] mag(input logic [23:0] v);
		logic [23:0] a;
		a = v[23] ? -v : v;
		// the most negative code has no positive twin, so it reads as full scale
		return a[23] ? 16'hffff : a[22:7];
	endfunction
	function automatic logic [7:0] mv(input logic [4:0] a);
		return mdl.exists(a) ? mdl[a] : 8'h00;
	endfunction
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// level control drops large gain codes, so the model does too
		if (mdl.exists(a) && !(a inside {A_LGAIN, A_RGAIN} && mdl[A_ALC][ALC_EN] && d > 8'h7f))
			mdl[a] = d;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] x);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, x);
	endtask
	task automatic frames(input int k);
		repeat (k) @(posedge clk_sys iff in_valid);
	endtask
	task automatic results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// peak model from each frame result, sampled mid-cycle when settled
	always @(negedge clk_sys) begin
		if (out_valid === 1'b1) begin
			if (mag(out_sample.left) > pk_l) pk_l = mag(out_sample.left);
			if (mag(out_sample.right) > pk_r) pk_r = mag(out_sample.right);
		end
	end
	// watchdog sized above the longest expected run
	initial begin
		repeat (90000) @(posedge clk_sys);
		fails++;
		results();
	end
////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hff47));
		{clk_sys, reg_wr, reg_rd, soft_mute_pin, alt, pk_l, pk_r} = '0;
		{rst, ce, run} = 3'h7;
		{reg_addr, reg_wdata, pair_select_pins, amp} = '0;
		mdl[A_SEL] = SEL_RST;
		mdl[A_MUTE] = 8'h00;
		mdl[A_TMR] = TMR_RST;
		mdl[A_LGAIN] = GAIN_RST;
		mdl[A_RGAIN] = GAIN_RST;
		mdl[A_ALC] = ALC_RST;
		mdl[A_REF] = REF_RST;
		mdl[A_LVOL] = VOL_RST;
		mdl[A_RVOL] = VOL_RST;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 1; a < 10; a++) begin
			rd(a[4:0], mv(a[4:0])); // reset values
		end
		rd(5'h1f, 8'h00);
		wr(A_MUTE, 8'h01); // mute before switching
		for (int p = 0; p < 8; p++) begin
			for (int r = 0; r < 8; r++) begin
				wr(A_SEL, r[7:0]);
				pair_select_pins <= p[2:0];
				@(posedge clk_sys);
				#1;
				e = (p == 0) ? (r > 4 ? 4 : r) : (p > 4 ? 4 : p);
				chk(input_pair_select, e); // pins take priority
				chk(pair_enable, 5'h01 << e); // one pair routed
			end
		end
		@(posedge clk_sys);
		pair_select_pins <= 3'h0;
		wr(A_MUTE, 8'h00); // unmute after switching
		amp <= 23'h010000;
		for (int c = 0; c < 4; c++) begin
			wr(A_TMR, c[7:0]);
			g = 8'h08 * (c + 1);
			wr(A_LGAIN, g);
			if (c == 0) begin
				frames(100);
				g = 8'h30;
				wr(A_LGAIN, g); // rewrite restarts timer
			end
			n = 0;
			while (left_analog_gain !== g && n < tmo[c] + 8) begin
				frames(1);
				#1;
				n++;
			end
			chk(left_analog_gain, g); // applied at timeout
			chk(n > tmo[c] - 8, 1'b1); // not before timeout
		end
		alt <= 1'b1;
		wr(A_RGAIN, 8'h18);
		frames(4);
		#1;
		chk(right_analog_gain, 8'h18); // applied at crossing
		@(posedge clk_sys);
		ce <= 1'b0;
		repeat (6) @(posedge clk_sys);
		ce <= 1'b1;
		amp <= 23'($urandom);
		frames(20);
		run <= 1'b0;
		repeat (8) @(posedge clk_sys);
		for (int ch = 0; ch < 2; ch++) begin
			pk = ch ? pk_r : pk_l;
			b = ch ? A_RPK_HI : A_LPK_HI;
			rd(b, pk[15:8]); // absolute peak upper
			rd(b + 5'h01, pk[7:0]); // lower after upper
			rd(b, 8'h00); // restarts from zero
			rd(b, 8'h00);
		end
		run <= 1'b1;
		amp <= 23'h100000;
		wr(A_LVOL, VOL_MAX);
		wr(A_RVOL, VOL_MAX);
		frames(150);
		#1;
		chk(mag(out_sample.left) > 16'h4000, 1'b1); // top code boosts
		for (int m = 0; m < 3; m++) begin
			@(posedge clk_sys);
			if (m == 0) soft_mute_pin <= 1'b1;
			if (m == 1) wr(A_MUTE, 8'h01);
			if (m == 2) wr(A_LVOL, 8'h00);
			if (m == 2) wr(A_RVOL, 8'h00);
			frames(1030);
			#1;
			chk(out_sample, 48'h0); // silent within limit
			wr(A_MUTE, 8'h00);
			soft_mute_pin <= 1'b0;
			wr(A_LVOL, VOL_MAX);
			wr(A_RVOL, VOL_MAX);
			frames(1030);
			#1;
			chk(mag(out_sample.right) > 16'h4000, 1'b1); // ramps back
		end
		wr(A_REF, 8'h24);
		wr(A_ALC, 8'h03);
		wr(A_LGAIN, 8'h90);
		rd(A_LGAIN, mv(A_LGAIN)); // large code ignored
		amp <= 23'h7fffff;
		frames(300);
		#1;
		chk(left_analog_gain < 8'h20 && left_analog_gain === right_analog_gain, 1'b1);
		@(posedge clk_sys);
		amp <= 23'h001000;
		g = left_analog_gain;
		// quiet input: one last limit period, then a step up every wait period
		frames(400);
		#1;
		chk(left_analog_gain > g && left_analog_gain <= 8'h24 && left_analog_gain === right_analog_gain, 1'b1);
		wr(A_ALC, 8'h00);
		frames(8);
		#1;
		chk(left_analog_gain, mv(A_LGAIN)); // back to written
		chk(right_analog_gain, mv(A_RGAIN)); // back to written
		results();
	end
endmodule
